// ===== pkg/pfr_consts.svh
`ifndef PFR_CONSTS_SVH
`define PFR_CONSTS_SVH

// ==================================================
// bus map
`define PFR_ADDR_W        8
`define PFR_TABLE_WORDS   16
`define PFR_TABLE_END     8'h40
`define PFR_OFF_PTR       8'h80
`define PFR_OFF_DATA      8'h84
`define PFR_RESP_OKAY     2'b00
`define PFR_RESP_SLVERR   2'b10
`define PFR_RESP_DECERR   2'b11
`define PFR_FILL_BYTE     8'hFF

// ==================================================
// header contents
`define PFR_SIG_B0        8'h53
`define PFR_SIG_B1        8'h46
`define PFR_SIG_B2        8'h44
`define PFR_SIG_B3        8'h50
`define PFR_MINOR_REV     8'h06
`define PFR_MAJOR_REV     8'h01
`define PFR_HDR_COUNT     8'h02
`define PFR_UNUSED        8'hFF
`define PFR_H1_ID         8'h00
`define PFR_H1_MINOR      8'h06
`define PFR_H1_LEN        8'h10
`define PFR_H1_PTR        24'h00_0030
`define PFR_H2_ID         8'h81
`define PFR_H2_MINOR      8'h00
`define PFR_H2_LEN        8'h06
`define PFR_H2_PTR        24'h00_0100
`define PFR_H3_MINOR      8'h00
`define PFR_H3_LEN        8'h18
`define PFR_H3_PTR        24'h00_0200
`define PFR_H3_BANK       8'h01
`define PFR_HDR_MAJOR     8'h01

// ==================================================
// basic table contents
`define PFR_ERASE_4K      2'b01
`define PFR_BUF64         1'b1
`define PFR_VOL_STATUS    1'b1
`define PFR_WREN_06       1'b1
`define PFR_B30_UNUSED    3'b111
`define PFR_ERASE4K_OP    8'h20
`define PFR_CAP_DUAL_OUT  1'b1
`define PFR_CAP_ADDR_MODE 2'b00
`define PFR_CAP_DTR       1'b0
`define PFR_CAP_DUAL_IO   1'b1
`define PFR_CAP_QUAD_IO   1'b1
`define PFR_CAP_QUAD_OUT  1'b1
`define PFR_DENSITY       32'h00FF_FFFF
`define PFR_QIO_DUMMY     5'b00100
`define PFR_QIO_MODE      3'b010
`define PFR_QIO_OP        8'hEB
`define PFR_QOUT_DUMMY    5'b01000
`define PFR_QOUT_MODE     3'b000
`define PFR_QOUT_OP       8'h6B
`define PFR_DOUT_DUMMY    5'b01000
`define PFR_DOUT_MODE     3'b000
`define PFR_DOUT_OP       8'h3B
`define PFR_DIO_DUMMY     5'b00000
`define PFR_DIO_MODE      3'b100
`define PFR_DIO_OP        8'hBB

`endif

// ===== pkg/pfr_pkg.sv
`include "pfr_consts.svh"

package pfr_pkg;

  typedef logic [`PFR_ADDR_W-1:0] pfr_addr_t;
  typedef logic [7:0]             pfr_byte_t;

  typedef struct packed {
    logic [31:0] data;
    logic [3:0]  strb;
  } pfr_wdata_s;

  typedef struct packed {
    logic [31:0] data;
    logic [1:0]  resp;
  } pfr_rdata_s;

endpackage : pfr_pkg

// ===== logic/pfr_table_rom.sv
// The address map and register access over AXI4-Lite were decided locally.
`timescale 1ns/10ps
`include "pfr_consts.svh"

module pfr_table_rom
  import pfr_pkg::*;
#(
  parameter logic [7:0] P_VENDOR_ID = 8'h5A  // arbitrary value
) (
  input  wire logic        i_clock,
  input  wire logic        i_resetn,
  input  wire logic        i_awvalid,
  output      logic        o_awready,
  input  wire pfr_addr_t   i_awaddr,
  input  wire logic        i_wvalid,
  output      logic        o_wready,
  input  wire pfr_wdata_s  i_w,
  output      logic        o_bvalid,
  input  wire logic        i_bready,
  output      logic [1:0]  o_bresp,
  input  wire logic        i_arvalid,
  output      logic        o_arready,
  input  wire pfr_addr_t   i_araddr,
  output      logic        o_rvalid,
  input  wire logic        i_rready,
  output      pfr_rdata_s  o_r
);

  // ==================================================
  // assertion clocking
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_resetn);

  // ==================================================
  // table contents
  // literals cannot be sliced, so multi-byte fields live as vectors
  localparam logic [23:0] H1_PTR  = `PFR_H1_PTR;
  localparam logic [23:0] H2_PTR  = `PFR_H2_PTR;
  localparam logic [23:0] H3_PTR  = `PFR_H3_PTR;
  localparam logic [31:0] DENSITY = `PFR_DENSITY;

  function automatic pfr_byte_t rom_byte(input logic [5:0] a);
    pfr_byte_t v;
    v = `PFR_FILL_BYTE;
    case (a)
      6'h00: v = `PFR_SIG_B0;
      6'h01: v = `PFR_SIG_B1;
      6'h02: v = `PFR_SIG_B2;
      6'h03: v = `PFR_SIG_B3;
      6'h04: v = `PFR_MINOR_REV;
      6'h05: v = `PFR_MAJOR_REV;
      6'h06: v = `PFR_HDR_COUNT;
      6'h07: v = `PFR_UNUSED;
      6'h08: v = `PFR_H1_ID;
      6'h09: v = `PFR_H1_MINOR;
      6'h0A: v = `PFR_HDR_MAJOR;
      6'h0B: v = `PFR_H1_LEN;
      6'h0C: v = H1_PTR[7:0];
      6'h0D: v = H1_PTR[15:8];
      6'h0E: v = H1_PTR[23:16];
      6'h0F: v = `PFR_UNUSED;
      6'h10: v = `PFR_H2_ID;
      6'h11: v = `PFR_H2_MINOR;
      6'h12: v = `PFR_HDR_MAJOR;
      6'h13: v = `PFR_H2_LEN;
      6'h14: v = H2_PTR[7:0];
      6'h15: v = H2_PTR[15:8];
      6'h16: v = H2_PTR[23:16];
      6'h17: v = `PFR_UNUSED;
      6'h18: v = P_VENDOR_ID;
      6'h19: v = `PFR_H3_MINOR;
      6'h1A: v = `PFR_HDR_MAJOR;
      6'h1B: v = `PFR_H3_LEN;
      6'h1C: v = H3_PTR[7:0];
      6'h1D: v = H3_PTR[15:8];
      6'h1E: v = H3_PTR[23:16];
      6'h1F: v = `PFR_H3_BANK;
      6'h30: v = {`PFR_B30_UNUSED, `PFR_WREN_06, `PFR_VOL_STATUS, `PFR_BUF64, `PFR_ERASE_4K};
      6'h31: v = `PFR_ERASE4K_OP;
      6'h32: v = {1'b1, `PFR_CAP_QUAD_OUT, `PFR_CAP_QUAD_IO, `PFR_CAP_DUAL_IO, `PFR_CAP_DTR,
                  `PFR_CAP_ADDR_MODE, `PFR_CAP_DUAL_OUT};
      6'h33: v = `PFR_UNUSED;
      6'h34: v = DENSITY[7:0];
      6'h35: v = DENSITY[15:8];
      6'h36: v = DENSITY[23:16];
      6'h37: v = DENSITY[31:24];
      6'h38: v = {`PFR_QIO_MODE, `PFR_QIO_DUMMY};
      6'h39: v = `PFR_QIO_OP;
      6'h3A: v = {`PFR_QOUT_MODE, `PFR_QOUT_DUMMY};
      6'h3B: v = `PFR_QOUT_OP;
      6'h3C: v = {`PFR_DOUT_MODE, `PFR_DOUT_DUMMY};
      6'h3D: v = `PFR_DOUT_OP;
      6'h3E: v = {`PFR_DIO_MODE, `PFR_DIO_DUMMY};
      6'h3F: v = `PFR_DIO_OP;
      default: v = `PFR_FILL_BYTE;
    endcase
    return v;
  endfunction : rom_byte

  // table is wired constants: nothing can alter it
  logic [31:0] rom_w [`PFR_TABLE_WORDS];

  for (genvar g = 0; g < `PFR_TABLE_WORDS; g++) begin : g_word
    assign rom_w[g] = {rom_byte(6'(4*g+3)), rom_byte(6'(4*g+2)),
                       rom_byte(6'(4*g+1)), rom_byte(6'(4*g))};
    a_word_read: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (ar_hs && i_araddr == 8'(4*g)) |=> (o_r.data == rom_w[g] && o_r.resp == `PFR_RESP_OKAY))
      else $error("table word read wrong");
  end

  // ==================================================
  // byte stream pointer
  pfr_byte_t  ptr_q;
  pfr_byte_t  stream_byte;
  logic       ar_hs;
  logic       wr_go;
  pfr_addr_t  aw_addr_q;
  pfr_wdata_s w_q;
  logic       aw_full_q;
  logic       w_full_q;

  assign ar_hs       = i_arvalid && o_arready;
  assign wr_go       = aw_full_q && w_full_q && !o_bvalid;
  // past the covered table the stream reads erased fill
  assign stream_byte = (ptr_q < `PFR_TABLE_END) ? rom_byte(ptr_q[5:0]) : `PFR_FILL_BYTE;

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      ptr_q <= 8'h00;
    end else if (wr_go && aw_addr_q == `PFR_OFF_PTR && w_q.strb[0]) begin
      ptr_q <= w_q.data[7:0];
    end else if (ar_hs && i_araddr == `PFR_OFF_DATA) begin
      ptr_q <= ptr_q + 8'h01;
    end
  end

  // ==================================================
  // write channel
  assign o_awready = !aw_full_q;
  assign o_wready  = !w_full_q;

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      aw_full_q <= 1'b0;
      aw_addr_q <= 8'h00;
    end else if (i_awvalid && o_awready) begin
      aw_full_q <= 1'b1;
      aw_addr_q <= i_awaddr;
    end else if (wr_go) begin
      aw_full_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      w_full_q <= 1'b0;
      w_q      <= '0;
    end else if (i_wvalid && o_wready) begin
      w_full_q <= 1'b1;
      w_q      <= i_w;
    end else if (wr_go) begin
      w_full_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      o_bvalid <= 1'b0;
      o_bresp  <= `PFR_RESP_OKAY;
    end else if (wr_go) begin
      o_bvalid <= 1'b1;
      if (aw_addr_q == `PFR_OFF_PTR) begin
        o_bresp <= `PFR_RESP_OKAY;
      end else if (aw_addr_q < `PFR_TABLE_END || aw_addr_q == `PFR_OFF_DATA) begin
        o_bresp <= `PFR_RESP_SLVERR;
      end else begin
        o_bresp <= `PFR_RESP_DECERR;
      end
    end else if (i_bready) begin
      o_bvalid <= 1'b0;
    end
  end

  // ==================================================
  // read channel
  assign o_arready = !o_rvalid;

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      o_rvalid <= 1'b0;
      o_r      <= '0;
    end else if (ar_hs) begin
      o_rvalid <= 1'b1;
      if (i_araddr < `PFR_TABLE_END) begin
        o_r <= '{data: rom_w[i_araddr[5:2]], resp: `PFR_RESP_OKAY};
      end else if (i_araddr == `PFR_OFF_PTR) begin
        o_r <= '{data: {24'h00_0000, ptr_q}, resp: `PFR_RESP_OKAY};
      end else if (i_araddr == `PFR_OFF_DATA) begin
        o_r <= '{data: {24'h00_0000, stream_byte}, resp: `PFR_RESP_OKAY};
      end else begin
        o_r <= '{data: 32'h0000_0000, resp: `PFR_RESP_DECERR};
      end
    end else if (i_rready) begin
      o_rvalid <= 1'b0;
    end
  end

  // ==================================================
  // header checks
  a_sig_word: assert property (
    (ar_hs && i_araddr == 8'h00)
      |=> (o_r.data == 32'h5044_4653))
    else $error("signature word wrong");

  a_sig_bytes: assert property (
    rom_w[0][7:0] == 8'h53 && rom_w[0][31:24] == 8'h50)
    else $error("signature bytes out of order");

  a_rev_word: assert property (
    (ar_hs && i_araddr == 8'h04)
      |=> (o_r.data == 32'hFF02_0106))
    else $error("revision word wrong");

  a_hdr_count: assert property (
    rom_w[1][23:16] == 8'h02)
    else $error("header count wrong");

  a_unused_byte: assert property (
    rom_w[1][31:24] == 8'hFF)
    else $error("unused header byte wrong");

  a_hdr_one: assert property (
    rom_w[2] == 32'h1001_0600 && rom_w[3] == 32'hFF00_0030)
    else $error("first header wrong");

  a_hdr_two: assert property (
    rom_w[4] == 32'h0601_0081 && rom_w[5] == 32'hFF00_0100)
    else $error("second header wrong");

  a_hdr_three: assert property (
    rom_w[6] == {16'h1801, 8'h00, P_VENDOR_ID} && rom_w[7] == 32'h0100_0200)
    else $error("third header wrong");

  a_ptr_aligned: assert property (
    rom_w[3][1:0] == 2'b00 && rom_w[5][1:0] == 2'b00 && rom_w[7][1:0] == 2'b00)
    else $error("table pointer not aligned");

  a_ptr_order: assert property (
    rom_w[3][23:0] == 24'h00_0030 && rom_w[5][23:0] == 24'h00_0100 && rom_w[7][23:0] == 24'h00_0200)
    else $error("table pointer byte order wrong");

  // ==================================================
  // basic table checks
  a_basic_one: assert property (
    (ar_hs && i_araddr == 8'h30)
      |=> (o_r.data == 32'hFFF1_20FD) && o_rvalid)
    else $error("basic dword one wrong");

  a_erase_bits: assert property (
    rom_w[12][1:0] == 2'b01 && rom_w[12][2] && rom_w[12][7:5] == 3'b111 && rom_w[12][15:8] == 8'h20)
    else $error("erase fields wrong");

  a_status_bits: assert property (
    rom_w[12][4:3] == 2'b11)
    else $error("status register fields wrong");

  a_cap_flags: assert property (
    rom_w[12][23] && rom_w[12][31:24] == 8'hFF)
    else $error("capability byte wrong");

  a_density_word: assert property (
    rom_w[13] == 32'h00FF_FFFF)
    else $error("density wrong");

  a_fast_quad: assert property (
    rom_w[14] == 32'h6B08_EB44)
    else $error("quad read dword wrong");

  a_fast_dual: assert property (
    rom_w[15] == 32'hBB80_3B08)
    else $error("dual read dword wrong");

  a_qio_timing: assert property (
    rom_w[14][4:0] == 5'b00100 && rom_w[14][7:5] == 3'b010)
    else $error("quad address timing wrong");

  a_qout_timing: assert property (
    rom_w[14][20:16] == 5'b01000 && rom_w[14][23:21] == 3'b000)
    else $error("quad output timing wrong");

  a_dout_timing: assert property (
    rom_w[15][4:0] == 5'b01000 && rom_w[15][7:5] == 3'b000)
    else $error("dual output timing wrong");

  a_dio_timing: assert property (
    rom_w[15][20:16] == 5'b00000 && rom_w[15][23:21] == 3'b100)
    else $error("dual address timing wrong");

  // bytes 20H-2FH belong to no covered table and read as fill
  a_fill_words: assert property (
    &{rom_w[8], rom_w[9], rom_w[10], rom_w[11]})
    else $error("fill words wrong");

  // ==================================================
  // stream pointer checks
  a_stream_step: assert property (
    (ar_hs && i_araddr == `PFR_OFF_DATA && !(wr_go && aw_addr_q == `PFR_OFF_PTR))
      |=> (ptr_q == $past(ptr_q) + 8'h01) && (o_r.data[7:0] == rom_byte($past(ptr_q[5:0]))
           || $past(ptr_q) >= `PFR_TABLE_END))
    else $error("stream pointer did not advance");

  a_stream_fill: assert property (
    (ar_hs && i_araddr == `PFR_OFF_DATA && ptr_q >= `PFR_TABLE_END)
      |=> (o_r.data == 32'h0000_00FF))
    else $error("stream past table not fill");

  a_ptr_load: assert property (
    (wr_go && aw_addr_q == `PFR_OFF_PTR && w_q.strb[0])
      |=> (ptr_q == $past(w_q.data[7:0])))
    else $error("pointer write lost");

  a_ptr_readback: assert property (
    (ar_hs && i_araddr == `PFR_OFF_PTR)
      |=> (o_r.data == {24'h00_0000, $past(ptr_q)}))
    else $error("pointer readback wrong");

  a_b_okay: assert property (
    (wr_go && aw_addr_q == `PFR_OFF_PTR)
      |=> (o_bresp == `PFR_RESP_OKAY))
    else $error("pointer write refused");

  // table reads and refused writes leave the pointer alone
  a_ptr_quiet: assert property (
    !(ar_hs && i_araddr == `PFR_OFF_DATA) && !(wr_go && aw_addr_q == `PFR_OFF_PTR)
      |=> $stable(ptr_q))
    else $error("pointer moved without cause");

  // ==================================================
  // bus checks
  a_rd_answer: assert property (
    ar_hs |=> o_rvalid)
    else $error("read not answered next cycle");

  a_r_drop: assert property (
    (o_rvalid && i_rready) |=> !o_rvalid)
    else $error("read data outstayed rready");

  a_wr_answer: assert property (
    wr_go |=> (o_bvalid && !aw_full_q && !w_full_q))
    else $error("write not answered");

  a_b_drop: assert property (
    (o_bvalid && i_bready) |=> !o_bvalid)
    else $error("write response outstayed bready");

  a_table_wr_err: assert property (
    (wr_go && aw_addr_q < `PFR_TABLE_END)
      |=> (o_bvalid && o_bresp == `PFR_RESP_SLVERR))
    else $error("table write not refused");

  a_wr_decerr: assert property (
    (wr_go && aw_addr_q >= `PFR_TABLE_END && aw_addr_q != `PFR_OFF_PTR && aw_addr_q != `PFR_OFF_DATA)
      |=> (o_bresp == `PFR_RESP_DECERR))
    else $error("unmapped write not decode error");

  a_rd_decerr: assert property (
    (ar_hs && i_araddr >= `PFR_TABLE_END && i_araddr != `PFR_OFF_PTR && i_araddr != `PFR_OFF_DATA)
      |=> (o_r.resp == `PFR_RESP_DECERR && o_r.data == 32'h0000_0000))
    else $error("unmapped read not decode error");

  // reset must reach the outputs, so the default disable is overridden
  a_reset_idle: assert property (disable iff (1'b0)
    !i_resetn |=> (!o_rvalid && !o_bvalid && ptr_q == 8'h00))
    else $error("reset did not clear the bus");

endmodule : pfr_table_rom

// ===== dv/pfr_host_model.sv
`timescale 1ns/10ps

// ==========================================
// bus host: one write and one read at a time
module pfr_host_model
  import pfr_pkg::*;
(
  input  wire logic       i_clock,
  output      logic       o_awvalid,
  input  wire logic       i_awready,
  output      pfr_addr_t  o_awaddr,
  output      logic       o_wvalid,
  input  wire logic       i_wready,
  output      pfr_wdata_s o_w,
  input  wire logic       i_bvalid,
  output      logic       o_bready,
  input  wire logic [1:0] i_bresp,
  output      logic       o_arvalid,
  input  wire logic       i_arready,
  output      pfr_addr_t  o_araddr,
  input  wire logic       i_rvalid,
  output      logic       o_rready,
  input  wire pfr_rdata_s i_r
);
  initial begin
    o_awvalid = 1'b0;
    o_awaddr  = '0;
    o_wvalid  = 1'b0;
    o_w       = '0;
    o_bready  = 1'b0;
    o_arvalid = 1'b0;
    o_araddr  = '0;
    o_rready  = 1'b0;
  end

  // released payloads are inverted so stale values never look valid
  task automatic wr(input pfr_addr_t a, input logic [31:0] d, output logic [1:0] resp);
    logic done;
    done = 1'b0;
    @(posedge i_clock);
    o_awvalid <= 1'b1;
    o_awaddr  <= a;
    o_wvalid  <= 1'b1;
    o_w       <= '{data: d, strb: 4'hF};
    o_bready  <= 1'b1;
    while (!done) begin
      @(posedge i_clock);
      if (o_awvalid && i_awready) begin
        o_awvalid <= 1'b0;
        o_awaddr  <= ~o_awaddr;
      end
      if (o_wvalid && i_wready) begin
        o_wvalid <= 1'b0;
        o_w      <= ~o_w;
      end
      if (i_bvalid) begin
        resp     = i_bresp;
        o_bready <= 1'b0;
        done     = 1'b1;
      end
    end
  endtask : wr

  task automatic rd(input pfr_addr_t a, output logic [31:0] d, output logic [1:0] resp);
    logic done;
    done = 1'b0;
    @(posedge i_clock);
    o_arvalid <= 1'b1;
    o_araddr  <= a;
    o_rready  <= 1'b1;
    while (!done) begin
      @(posedge i_clock);
      if (o_arvalid && i_arready) begin
        o_arvalid <= 1'b0;
        o_araddr  <= ~o_araddr;
      end
      if (i_rvalid) begin
        d        = i_r.data;
        resp     = i_r.resp;
        o_rready <= 1'b0;
        done     = 1'b1;
      end
    end
  endtask : rd
endmodule : pfr_host_model

// ===== dv/pfr_table_rom_tb_top.sv
`timescale 1ns/10ps
`include "pfr_consts.svh"

module pfr_table_rom_tb_top
  import pfr_pkg::*;
;
  localparam logic [7:0]  VID = 8'h3C;  // arbitrary value
  localparam logic [31:0] EXP [16] = '{32'h5044_4653, 32'hFF02_0106, 32'h1001_0600, 32'hFF00_0030,
    32'h0601_0081, 32'hFF00_0100, {24'h1801_00, VID}, 32'h0100_0200, 32'hFFFF_FFFF, 32'hFFFF_FFFF,
    32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFF1_20FD, 32'h00FF_FFFF, 32'h6B08_EB44, 32'hBB80_3B08};
  localparam logic [23:0] PTRS [3] = '{24'h00_0030, 24'h00_0100, 24'h00_0200};

  logic        i_clock;
  logic        i_resetn;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0]  bresp;
  pfr_addr_t   awaddr, araddr;
  pfr_wdata_s  w;
  pfr_rdata_s  r;
  int          mismatches;
  int          compares;

  pfr_table_rom #(.P_VENDOR_ID(VID)) u_pfr_table_rom (
    .i_clock(i_clock), .i_resetn(i_resetn), .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr),
    .i_wvalid(wvalid), .o_wready(wready), .i_w(w), .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
    .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr), .o_rvalid(rvalid), .i_rready(rready),
    .o_r(r));

  pfr_host_model u_pfr_host_model (
    .i_clock(i_clock), .o_awvalid(awvalid), .i_awready(awready), .o_awaddr(awaddr), .o_wvalid(wvalid),
    .i_wready(wready), .o_w(w), .i_bvalid(bvalid), .o_bready(bready), .i_bresp(bresp),
    .o_arvalid(arvalid), .i_arready(arready), .o_araddr(araddr), .i_rvalid(rvalid), .o_rready(rready),
    .i_r(r));

  // ==========================================
  // checking and closing
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test

  // ==========================================
  // scenarios
  task automatic t_table();
    logic [31:0] d;
    logic [1:0]  rsp;
    u_pfr_host_model.rd(`PFR_OFF_PTR, d, rsp);
    chk({24'h0, d[7:0]}, 32'h0);
    for (int i = 0; i < 16; i++) begin
      u_pfr_host_model.rd(8'(i * 4), d, rsp);
      chk(d, EXP[i]);
      chk({30'h0, rsp}, {30'h0, `PFR_RESP_OKAY});
    end
  endtask : t_table

  // host follows the first header's pointer to the basic table
  task automatic t_pointer();
    logic [31:0] d;
    logic [31:0] t;
    logic [1:0]  rsp;
    for (int k = 0; k < 3; k++) begin
      u_pfr_host_model.rd(8'(8'h0C + 8 * k), d, rsp);
      chk({8'h0, d[23:0]}, {8'h0, PTRS[k]});
      chk({30'h0, d[1:0]}, 32'h0);
      if (k == 0) begin
        u_pfr_host_model.rd(d[7:0], t, rsp);
        chk(t, 32'hFFF1_20FD);
      end
    end
  endtask : t_pointer

  // stream crosses the end of the basic table into fill bytes
  task automatic t_stream();
    logic [31:0] d;
    logic [31:0] e;
    logic [7:0]  p;
    logic [1:0]  rsp;
    u_pfr_host_model.wr(`PFR_OFF_PTR, 32'h3C, rsp);
    chk({30'h0, rsp}, {30'h0, `PFR_RESP_OKAY});
    for (int k = 0; k < 6; k++) begin
      p = 8'(8'h3C + k);
      e = (p < 8'h40) ? EXP[p[5:2]] >> (8 * p[1:0]) : 32'hFF;
      u_pfr_host_model.rd(`PFR_OFF_DATA, d, rsp);
      chk({24'h0, d[7:0]}, {24'h0, e[7:0]});
    end
    u_pfr_host_model.rd(`PFR_OFF_PTR, d, rsp);
    chk({24'h0, d[7:0]}, 32'h42);
  endtask : t_stream

  task automatic t_protect();
    logic [31:0] d;
    logic [1:0]  rsp;
    u_pfr_host_model.wr(8'h04, 32'h0, rsp);
    chk({30'h0, rsp}, {30'h0, `PFR_RESP_SLVERR});
    u_pfr_host_model.wr(`PFR_OFF_DATA, 32'h0, rsp);
    chk({30'h0, rsp}, {30'h0, `PFR_RESP_SLVERR});
    u_pfr_host_model.rd(8'h04, d, rsp);
    chk(d, EXP[1]);
    u_pfr_host_model.rd(`PFR_OFF_PTR, d, rsp);
    chk({24'h0, d[7:0]}, 32'h42);
    u_pfr_host_model.wr(8'h90, 32'h0, rsp);
    chk({30'h0, rsp}, {30'h0, `PFR_RESP_DECERR});
    u_pfr_host_model.rd(8'h90, d, rsp);
    chk({30'h0, rsp}, {30'h0, `PFR_RESP_DECERR});
    chk(d, 32'h0);
  endtask : t_protect

  // reset in mid-run puts the stream pointer back to its start
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0]  rsp;
    u_pfr_host_model.wr(`PFR_OFF_PTR, 32'h10, rsp);
    u_pfr_host_model.rd(`PFR_OFF_PTR, d, rsp);
    chk({24'h0, d[7:0]}, 32'h10);
    @(posedge i_clock);
    i_resetn <= 1'b0;
    repeat (2) @(posedge i_clock);
    i_resetn <= 1'b1;
    u_pfr_host_model.rd(`PFR_OFF_PTR, d, rsp);
    chk({24'h0, d[7:0]}, 32'h0);
  endtask : t_reset

  // ==========================================
  // clock, reset, sequence, watchdog
  initial begin
    i_clock = 1'b0;
    forever #4 i_clock = ~i_clock;
  end

  initial begin
    mismatches = 0;
    compares   = 0;
    i_resetn   = 1'b0;
    repeat (4) @(posedge i_clock);
    i_resetn <= 1'b1;
    t_table();
    t_pointer();
    t_stream();
    t_protect();
    t_reset();
    stop_test();
  end

  // whole run needs about 130 cycles
  initial begin
    repeat (5000) @(posedge i_clock);
    mismatches++;
    stop_test();
  end
endmodule : pfr_table_rom_tb_top
